// ===== core/smp_master.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "smp_consts.svh"
module smp_master (
  input  wire logic            clk,        // 25 MHz system clock
  input  wire logic            rst_b,      // sync reset, low
  input  wire logic            wb_cyc_i,   // wishbone cycle
  input  wire logic            wb_stb_i,   // wishbone strobe
  input  wire logic            wb_we_i,    // write enable
  input  wire logic [7:0]      wb_adr_i,   // register address
  input  wire logic [0:0]      wb_sel_i,   // byte select
  input  wire smp_pkg::smp_byte_t wb_dat_i, // write data
  output smp_pkg::smp_byte_t   wb_dat_o,   // read data
  output logic                 wb_ack_o,   // acknowledge
  input  wire logic [2:0]      portOut,    // gpio output values
  input  wire logic [2:0]      portDir,    // gpio dir, 1 = input
  output logic                 pinClkO,    // pin 0 level
  output logic                 pinClkOe,   // pin 0 enable
  output logic                 masterOutPinO,  // pin 1 level
  output logic                 masterOutPinOe, // pin 1 enable
  output logic                 pin2O,      // pin 2 level
  output logic                 pin2Oe,     // pin 2 enable
  input  wire logic            masterInPin // pin 2 input
);
  import smp_pkg::*;
  ////////////////////////////////////////////////////////////////////
  smp_state_t state_reg;
  smp_byte_t  ctrl_reg;
  smp_byte_t  shift_reg;
  smp_byte_t  rxBuf_reg;
  logic       collision_reg;
  logic       sck_reg;
  logic [4:0] edge_reg;
  logic [2:0] sampleDly_reg;
  logic       miSync;
  smp_cfg_if  cfg ();

  smp_rate_div u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .cfg   (cfg)
  );
  smp_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (masterInPin),
    .dout  (miSync)
  );
  ////////////////////////////////////////////////////////////////////
  wire ifaceEnable = ctrl_reg[`SMP_BIT_EN];
  wire bitOrder    = ctrl_reg[`SMP_BIT_ORDER];
  wire clkPolarity = ctrl_reg[`SMP_BIT_POL];
  wire clkPhase    = ctrl_reg[`SMP_BIT_PHA];
  wire busy        = (state_reg != SMP_IDLE);
  wire req         = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrEn        = req && wb_we_i && wb_sel_i[0];
  wire hitCtrl     = (wb_adr_i == `SMP_ADDR_CTRL);
  wire hitData     = (wb_adr_i == `SMP_ADDR_DATA);
  wire hitStat     = (wb_adr_i == `SMP_ADDR_STAT);
  wire dataWr      = wrEn && hitData;
  wire start       = dataWr && ifaceEnable && !busy;
  wire collide     = dataWr && busy;
  // even edge count is leading edge
  wire leadEdge    = !edge_reg[0];
  wire sampleNow   = cfg.tick && (leadEdge != clkPhase);
  wire driveNow    = cfg.tick && (leadEdge == clkPhase) && edge_reg != 5'h00;
  wire lastEdge    = cfg.tick && edge_reg == `SMP_EDGES - 5'h01;
  // a sample still on its way through the input lag
  wire settling    = |sampleDly_reg;
  wire outBit      = bitOrder ? shift_reg[7] : shift_reg[0];
  assign cfg.rate  = ctrl_reg[1:0];
  assign cfg.run   = (state_reg == SMP_SHIFT);

  function automatic smp_byte_t shiftIn(input smp_byte_t v, input logic ord, input logic b);
    shiftIn = ord ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  wire [7:0] rdMux = hitCtrl ? (ctrl_reg & `SMP_CTRL_MASK) :
                     hitData ? rxBuf_reg :
                     hitStat ? {6'h00, busy, collision_reg} : 8'h00;
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `SMP_BYTE_RST;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      ctrl_reg <= `SMP_CTRL_RST;
    else if (wrEn && hitCtrl)
      ctrl_reg <= wb_dat_i & `SMP_CTRL_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      collision_reg <= 1'b0;
    else if (dataWr)
      collision_reg <= collide;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= SMP_IDLE;
      edge_reg  <= 5'h00;
    end else begin
      case (state_reg)
        SMP_IDLE: begin
          edge_reg <= 5'h00;
          if (start)
            state_reg <= SMP_SHIFT;
        end
        SMP_SHIFT: begin
          if (cfg.tick)
            edge_reg <= edge_reg + 5'h01;
          if (lastEdge)
            state_reg <= SMP_DONE;
        end
        SMP_DONE: begin
          if (!settling)
            state_reg <= SMP_IDLE;
        end
        default:  state_reg <= SMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      shift_reg <= `SMP_BYTE_RST;
    else if (start)
      shift_reg <= wb_dat_i;
    else if (sampleDly_reg[`SMP_LAG_TOP])
      shift_reg <= shiftIn(shift_reg, bitOrder, miSync);
  end

  // pin input lags three cycles, so the shift waits as long;
  // the fastest rate leaves just enough room before the next drive
  always_ff @(posedge clk) begin
    if (!rst_b)
      sampleDly_reg <= 3'h0;
    else
      sampleDly_reg <= {sampleDly_reg[1:0], state_reg == SMP_SHIFT && sampleNow};
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      rxBuf_reg <= `SMP_BYTE_RST;
    else if (state_reg == SMP_DONE && !settling)
      rxBuf_reg <= shift_reg;
  end

  // toggles each tick, idles at polarity
  always_ff @(posedge clk) begin
    if (!rst_b)
      sck_reg <= 1'b0;
    else if (state_reg == SMP_SHIFT && cfg.tick)
      sck_reg <= !sck_reg;
    else if (state_reg != SMP_SHIFT)
      sck_reg <= clkPolarity;
  end
  ////////////////////////////////////////////////////////////////////
  logic dataOut_reg;
  always_ff @(posedge clk) begin
    if (!rst_b)
      dataOut_reg <= 1'b0;
    else if (start)
      dataOut_reg <= bitOrder ? wb_dat_i[7] : wb_dat_i[0];
    else if (state_reg == SMP_SHIFT && driveNow)
      dataOut_reg <= outBit;
  end

  // clock out, input in, data out follows dir
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinClkO        <= 1'b0;
      pinClkOe       <= 1'b0;
      masterOutPinO  <= 1'b0;
      masterOutPinOe <= 1'b0;
      pin2O          <= 1'b0;
      pin2Oe         <= 1'b0;
    end else begin
      pinClkO        <= ifaceEnable ? sck_reg : portOut[0];
      pinClkOe       <= ifaceEnable ? 1'b1 : !portDir[0];
      masterOutPinO  <= ifaceEnable ? dataOut_reg : portOut[1];
      masterOutPinOe <= !portDir[1];
      pin2O          <= ifaceEnable ? 1'b0 : portOut[2];
      pin2Oe         <= ifaceEnable ? 1'b0 : !portDir[2];
    end
  end
  ////////////////////////////////////////////////////////////////////
  sequence s_wr_busy;
    dataWr && busy;
  endsequence

  sequence s_flag_up;
    ##1 collision_reg;
  endsequence

  sequence s_shift_tick;
    state_reg == SMP_SHIFT && cfg.tick;
  endsequence

  sequence s_gap_fast;
    !cfg.tick [*3];
  endsequence

  sequence s_gap_slow;
    !cfg.tick [*7];
  endsequence

  sequence s_back_idle;
    ##[1:4] state_reg == SMP_IDLE;
  endsequence

  a_collide_drop: assert property (@(posedge clk) disable iff (!rst_b)
    collide |=> $stable(shift_reg) || $past(sampleDly_reg[`SMP_LAG_TOP]))
    else $error("collided write changed state");

  a_collide_flag: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_busy |-> s_flag_up)
    else $error("collision flag not set");

  a_clean_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (dataWr && !busy) |=> !collision_reg)
    else $error("collision flag not cleared");

  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !dataWr |=> $stable(collision_reg))
    else $error("collision flag moved without write");

  a_start_active: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> state_reg == SMP_SHIFT)
    else $error("transfer did not start");

  a_off_nostart: assert property (@(posedge clk) disable iff (!rst_b)
    (dataWr && !ifaceEnable && !busy) |=> state_reg == SMP_IDLE)
    else $error("transfer started while disabled");

  a_idle_clock: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_IDLE && $past(state_reg) == SMP_IDLE && $stable(clkPolarity))
      |-> sck_reg == clkPolarity)
    else $error("clock not idle at polarity");

  a_buf_stable: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(state_reg) != SMP_DONE) |-> $stable(rxBuf_reg))
    else $error("buffer moved early");

  a_active_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_DONE && !settling) |=> !busy && rxBuf_reg == $past(shift_reg))
    else $error("buffer and active flag out of step");

  a_edge_count: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_DONE && $past(state_reg) == SMP_SHIFT)
      |-> $past(edge_reg) == `SMP_EDGES - 5'h01)
    else $error("edge count wrong");

  a_edge_range: assert property (@(posedge clk) disable iff (!rst_b)
    edge_reg <= `SMP_EDGES)
    else $error("edge counter overran");

  a_done_entry: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_SHIFT && lastEdge) |=> state_reg == SMP_DONE)
    else $error("frame did not end after last edge");

  a_settle_bound: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SMP_DONE |-> s_back_idle)
    else $error("active held too long after frame");

  a_tick_run: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tick |-> $past(state_reg) == SMP_SHIFT)
    else $error("rate tick outside a frame");

  a_tick_fast: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg.tick && cfg.rate == 2'h0) |=> s_gap_fast)
    else $error("rate code 0 tick spacing wrong");

  a_tick_slow: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg.tick && cfg.rate == 2'h1) |=> s_gap_slow)
    else $error("rate code 1 tick spacing wrong");

  a_sck_toggle: assert property (@(posedge clk) disable iff (!rst_b)
    s_shift_tick |=> sck_reg != $past(sck_reg))
    else $error("serial clock missed a tick");

  a_sck_still: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_SHIFT && !cfg.tick) |=> $stable(sck_reg))
    else $error("serial clock moved between ticks");

  a_lag_msb: assert property (@(posedge clk) disable iff (!rst_b)
    (sampleDly_reg[`SMP_LAG_TOP] && bitOrder) |=> shift_reg[0] == $past(miSync))
    else $error("msb first sample misplaced");

  a_lag_lsb: assert property (@(posedge clk) disable iff (!rst_b)
    (sampleDly_reg[`SMP_LAG_TOP] && !bitOrder) |=> shift_reg[7] == $past(miSync))
    else $error("lsb first sample misplaced");

  a_first_bit: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> dataOut_reg == (bitOrder ? $past(wb_dat_i[7]) : $past(wb_dat_i[0])))
    else $error("first bit not placed by order");

  a_drive_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SMP_SHIFT && !driveNow) |=> $stable(dataOut_reg))
    else $error("data out moved off its drive edge");

  a_pin_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ifaceEnable |=> pinClkO == $past(sck_reg) && masterOutPinO == $past(dataOut_reg))
    else $error("pins not following the serial logic");

  a_clk_pin_oe: assert property (@(posedge clk) disable iff (!rst_b)
    $past(ifaceEnable) |-> pinClkOe && !pin2Oe)
    else $error("pin direction not forced");

  a_out_dir: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> masterOutPinOe == !$past(portDir[1]))
    else $error("data out enable ignores its direction bit");

  a_gpio_pass: assert property (@(posedge clk) disable iff (!rst_b)
    !ifaceEnable |=> pinClkOe == !$past(portDir[0]) && pin2Oe == !$past(portDir[2]))
    else $error("disabled pins not plain port pins");

  a_ctrl_bit7: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl_reg[7])
    else $error("control bit 7 set");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wrEn && hitCtrl) |=> ctrl_reg == ($past(wb_dat_i) & `SMP_CTRL_MASK))
    else $error("control write not stored");

  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_we_i && hitCtrl) |=> !wb_dat_o[7])
    else $error("control bit 7 read back set");

  a_stat_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_we_i && hitStat) |=> wb_dat_o[7:2] == 6'h00)
    else $error("status upper bits not zero");

  a_stat_read: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_we_i && hitStat) |=> wb_dat_o[1] == $past(busy))
    else $error("active bit read wrong");

  a_data_read: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_we_i && hitData) |=> wb_dat_o == $past(rxBuf_reg))
    else $error("data read not from input buffer");
endmodule

// ===== include/smp_consts.svh
// What this block does
// - setting the enable bit hands three port pins to the serial clock, data out and data in.
// - while enabled the clock pin is forced to output and the input pin to input, data out follows its direction bit.
// - the bit order field picks LSB first at 0 and MSB first at 1 for both directions.
// - the polarity bit sets the idle level of the serial clock, 0 low and 1 high.
// - the phase bit swaps which clock edge drives data and which samples it.
// - the rate field divides the system clock by 8, 16, 32 or 64 for codes 0 to 3.
// - a data write while enabled starts a transfer of exactly eight bits each way.
// - data reads return an input buffer loaded only when a transfer completes.
// - a data write during a transfer is a collision and the byte is dropped.
// - every data write updates the collision flag to 1 if it collided and 0 if not.
// - the active bit reads 1 from the start of a transfer until its last sample has settled after the shift.
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH
`define SMP_ADDR_CTRL   8'ha1
`define SMP_ADDR_DATA   8'ha2
`define SMP_ADDR_STAT   8'ha3
`define SMP_BIT_EN      5
`define SMP_BIT_ORDER   4
`define SMP_BIT_POL     3
`define SMP_BIT_PHA     2
`define SMP_CTRL_MASK   8'h7f
`define SMP_CTRL_RST    8'h00
`define SMP_BYTE_RST    8'h00
`define SMP_HALF_BASE   6'h04
`define SMP_EDGES       5'h10
`define SMP_LAG_TOP     2
`define SMP_CLK_HZ      25000000
`endif

// ===== include/smp_pkg.sv
package smp_pkg;
  typedef enum logic [1:0] {
    SMP_IDLE  = 2'b00,
    SMP_SHIFT = 2'b01,
    SMP_DONE  = 2'b10
  } smp_state_t;
  typedef logic [7:0] smp_byte_t;
endpackage

// ===== include/smp_cfg_if.sv
`timescale 1ns/1ps
interface smp_cfg_if;
  logic [1:0] rate;
  logic       run;
  logic       tick;
  modport src (input rate, input run, output tick);
  modport dst (output rate, output run, input tick);
endinterface

// ===== core/smp_rate_div.sv
`timescale 1ns/1ps
`include "smp_consts.svh"
module smp_rate_div (
  input  wire logic clk,      // system clock
  input  wire logic rst_b,    // sync reset, low
  smp_cfg_if.src    cfg       // rate in, tick out
);
  import smp_pkg::*;
  logic [4:0] cnt_reg;
  logic [5:0] half;
  logic       tick_reg;
  // half period doubles per rate code
  assign half = `SMP_HALF_BASE << cfg.rate;
  assign cfg.tick = tick_reg;
  always_ff @(posedge clk) begin
    if (!rst_b || !cfg.run) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else if ({1'b0, cnt_reg} == half - 6'h01) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 5'h01;
      tick_reg <= 1'b0;
    end
  end
endmodule

// ===== core/smp_sync.sv
`timescale 1ns/1ps
module smp_sync (
  input  wire logic clk,      // system clock
  input  wire logic rst_b,    // sync reset, low
  input  wire logic din,      // async pin
  output logic      dout      // settled level
);
  logic [2:0] sh_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sh_reg <= 3'h0;
      dout   <= 1'b0;
    end else begin
      sh_reg <= {sh_reg[1:0], din};
      // change counts once stages two and three agree
      if (sh_reg[1] == sh_reg[2])
        dout <= sh_reg[2];
    end
  end
endmodule

// ===== verif/smp_peer.sv
`timescale 1ns/1ps
module smp_peer (
  input  wire logic       sck,     // serial clock pin
  input  wire logic       mosi,    // data from master
  output logic            miso,    // data to master
  input  wire logic [2:0] mode,    // order, polarity, phase
  input  wire logic       load,    // toggles per frame
  input  wire logic [7:0] txByte,  // byte to return
  output logic [7:0]      rxByte   // byte captured
);
  int         nIn;
  int         nOut;
  logic [7:0] tx;
  function automatic logic pick(int k);
    return mode[2] ? tx[7-k] : tx[k];
  endfunction
  // counters start spent so clock moves before the first frame capture nothing and only toggle miso
  initial begin
    miso = 1'b0;
    tx = 8'h00;
    nIn = 8;
    nOut = 8;
  end
  ////////////////////////////////////////////////////////////////////
  // separate lines, select kept by software
  always @(load) begin
    tx = txByte;
    nIn = 0;
    nOut = mode[0] ? 0 : 1;
    miso = mode[0] ? ~miso : pick(0);
  end
  // sample on one edge kind, drive on the other
  always @(sck) begin
    if ((sck !== mode[1]) == !mode[0]) begin
      if (nIn < 8) rxByte[mode[2] ? 7-nIn : nIn] = mosi;
      nIn++;
    end else begin
      // past the last bit the line no longer holds data
      miso = (nOut < 8) ? pick(nOut) : ~miso;
      nOut++;
    end
  end
endmodule

// ===== verif/spi_master_port_tb_top.sv
`timescale 1ns/1ps
`include "smp_consts.svh"
module spi_master_port_tb_top;
  import smp_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t: got %0h exp %0h", $time, g, e); end end
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cyc, stb, we, load, miso, sckLast;
  logic [7:0] adr, datW, rd, x, c, prev;
  logic [2:0] pOut, pDir, mode;
  smp_byte_t  datO, rxPeer, txPeer;
  logic       ack, sck, sckOe, mo, moOe, p2, p2Oe;
  int         fail_count, samples_checked, cycN, edges, t0, tl;
  always #20 clk = ~clk;
  smp_master dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(1'b1), .wb_dat_i(datW), .wb_dat_o(datO), .wb_ack_o(ack),
    .portOut(pOut), .portDir(pDir), .pinClkO(sck), .pinClkOe(sckOe), .masterOutPinO(mo),
    .masterOutPinOe(moOe), .pin2O(p2), .pin2Oe(p2Oe), .masterInPin(miso));
  smp_peer peer_u (.sck(sck), .mosi(mo), .miso(miso), .mode(mode), .load(load),
    .txByte(txPeer), .rxByte(rxPeer));
  ////////////////////////////////////////////////////////////////////
  // edge count and span of the serial clock, in system cycles
  always @(posedge clk) begin
    cycN++;
    if (sck !== sckLast) begin
      edges++;
      if (edges == 1) t0 = cycN;
      tl = cycN;
    end
    sckLast = sck;
  end
  task automatic conclude;
    $display("errors %0d checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      $display("BAD %0t: no acknowledge", $time);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    int n;
    void'($urandom(32'h539e4fe3));
    {cyc, stb, we, load, sckLast, adr, datW, pOut, pDir, mode, txPeer, prev} = '0;
    {fail_count, samples_checked, cycN, edges} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      wb(1'b0, 8'ha0 + 8'(a), 8'h00);
      `CHK(rd, 8'h00)
    end
    pOut <= 3'($urandom);
    pDir <= 3'($urandom);
    wb(1'b1, `SMP_ADDR_DATA, 8'h5a);
    wb(1'b0, `SMP_ADDR_STAT, 8'h00);
    `CHK(rd, 8'h00)
    `CHK(sck, pOut[0])
    `CHK(sckOe, ~pDir[0])
    `CHK(mo, pOut[1])
    `CHK(moOe, ~pDir[1])
    `CHK(p2Oe, ~pDir[2])
    for (int i = 0; i < 32; i++) begin
      c = 8'({2'b10, 1'b1, i[2:0], i[4:3]});
      mode <= i[2:0];
      // full duplex keeps the out pin driving
      pDir <= 3'($urandom) & 3'b101;
      wb(1'b1, `SMP_ADDR_CTRL, c);
      wb(1'b0, `SMP_ADDR_CTRL, 8'h00);
      `CHK(rd, c & 8'h7f)
      x = 8'($urandom);
      txPeer <= 8'($urandom);
      load <= ~load;
      @(posedge clk);
      `CHK(sck, i[1])
      `CHK({sckOe, moOe, p2Oe}, 3'b110)
      edges = 0;
      wb(1'b1, `SMP_ADDR_DATA, x);
      wb(1'b0, `SMP_ADDR_STAT, 8'h00);
      `CHK(rd, 8'h02)
      if (i[0]) begin
        wb(1'b1, `SMP_ADDR_DATA, ~x);
        wb(1'b0, `SMP_ADDR_STAT, 8'h00);
        `CHK(rd, 8'h03)
        wb(1'b0, `SMP_ADDR_DATA, 8'h00);
        `CHK(rd, prev)
      end
      n = 0;
      do begin wb(1'b0, `SMP_ADDR_STAT, 8'h00); n++; end while (rd[1] !== 1'b0 && n < 400);
      `CHK(rd[1], 1'b0)
      `CHK(edges, 16)
      `CHK(tl - t0, 15 * (4 << i[4:3]))
      `CHK(sck, i[1])
      `CHK(rxPeer, x)
      wb(1'b0, `SMP_ADDR_DATA, 8'h00);
      `CHK(rd, txPeer)
      prev = txPeer;
    end
    conclude();
  end
endmodule
